// ### heater_cycle_map.vh
`ifndef HEATER_CYCLE_MAP_VH
`define HEATER_CYCLE_MAP_VH
// ==========================================
// register offsets (word index)
`define REG_CTRL      4'h0
`define REG_SETPOINT  4'h1
`define REG_DEADBAND  4'h2
`define REG_PLIMIT    4'h3
`define REG_TEMP      4'h4
`define REG_STATUS    4'h5
`define REG_AVG_CUR   4'h6
`define REG_AVG_GF    4'h7
`define REG_AVG_VOLT  4'h8
`define REG_MEAN_ERR  4'h9
// ==========================================
// control bit positions
`define CTRL_HEAT_EN  0
`define CTRL_PROP     1
`define CTRL_PLIM_EN  2
// ==========================================
// sampling channels
`define CH_CUR        2'h0
`define CH_GF         2'h1
`define CH_VOLT       2'h2
// ==========================================
// frame and sampling constants
`define FRAME_LEN     4'hA
`define FRAME_LAST    4'h9
`define DUTY_FULL     4'hA
`define SAMPLES       9'h12C
`define SETTLE_FRAMES 2'h2
// ==========================================
// slope factor limits and reset values
`define SLOPE_MIN     4'h1
`define SLOPE_MAX     4'hA
`define SLOPE_RST     4'h5
// ==========================================
// timing: one second in cycles at 10 MHz, one hour in seconds
`define CLK_HZ        10000000
`define HOUR_SECS     3600
`endif

// ### heater_cycle_modulation_ctrl.v
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "heater_cycle_map.vh"

// Overview of operation
// - 300 synced samples span ten mains cycles
// - samples are 10-bit converted values
// - ten-cycle frame, whole cycles on/off
// - duty 0-100% in 10% steps
// - fixed pattern per duty, every frame
// - switch changes only at zero crossings
// - power limit holds duty whose current equals limit, else alternates around it
// - above limit, lower duty one step
// - below limit, raise duty one step
// - wait for settled current before stepping
// - new demand starts at zero, ramps up
// - proportional mode uses frame modulation
// - duty from error over slope factor
// - slope factor retuned hourly within 1-10
// - hourly mean of absolute error
// - better keeps direction, worse reverses
// - on/off demand with deadband hysteresis
module heater_cycle_modulation_ctrl #(
    parameter SEC_CYCLES = `CLK_HZ,
    parameter HOUR_SECS  = `HOUR_SECS
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // mains and sampling front end
    input  wire        zeroCross,
    input  wire        sampleValid,
    input  wire [1:0]  sampleChan,
    input  wire [9:0]  sampleData,
    // register port
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [15:0] regRdData,
    // heater switch
    output reg         heaterOn
);

    // ==========================================
    // helper functions
    // on/off for a frame position, evenly spread
    function patternBit;
        input [3:0] duty;
        input [3:0] pos;
        reg   [7:0] a;
        reg   [7:0] b;
        begin
            a = ({4'h0, pos} + 8'h01) * {4'h0, duty};
            b = {4'h0, pos} * {4'h0, duty};
            patternBit = (a / {4'h0, `FRAME_LEN}) != (b / {4'h0, `FRAME_LEN});
        end
    endfunction

    // proportional duty in tenths
    function [3:0] propDuty;
        input signed [16:0] err;
        input        [3:0]  slope;
        reg          [7:0]  t;
        begin
            t = 8'h00;
            if (err <= 17'sd0)
                propDuty = 4'h0;
            else if (err >= $signed({13'h0, slope}))
                propDuty = `DUTY_FULL;
            else begin
                t = err[7:0] * {4'h0, `DUTY_FULL} / {4'h0, slope};
                propDuty = t[3:0];
            end
        end
    endfunction

    // frame sum to per-sample average, always fits ten bits
    function [9:0] frameAvg;
        input [18:0] sum;
        reg   [18:0] q;
        begin
            q = sum / {10'h0, `SAMPLES};
            frameAvg = q[9:0];
        end
    endfunction

    // ==========================================
    // registers
    reg        [2:0]  ctrl_q;
    reg signed [15:0] setpoint_q;
    reg        [15:0] deadband_q;
    reg        [9:0]  plimit_q;
    reg signed [15:0] temp_q;
    reg        [3:0]  pos_q;
    reg        [3:0]  duty_q;
    reg        [8:0]  sampCnt_q;
    reg        [18:0] sumCur_q;
    reg        [18:0] sumGf_q;
    reg        [18:0] sumVolt_q;
    reg        [9:0]  avgCur_q;
    reg        [9:0]  avgGf_q;
    reg        [9:0]  avgVolt_q;
    reg        [1:0]  settle_q;
    reg               demand_q;
    reg               hyst_q;
    reg        [3:0]  slope_q;
    reg               slopeUp_q;
    reg        [31:0] secCnt_q;
    reg        [15:0] hourSecs_q;
    reg        [31:0] errSum_q;
    reg        [19:0] errCnt_q;
    reg        [15:0] meanErr_q;
    reg        [15:0] prevErr_q;

    wire signed [16:0] err    = {setpoint_q[15], setpoint_q} - {temp_q[15], temp_q};
    wire        [16:0] absErr = err[16] ? (~err + 17'h1) : err;
    wire signed [16:0] lowTh  = {setpoint_q[15], setpoint_q} - $signed({1'b0, deadband_q});
    wire signed [16:0] highTh = {setpoint_q[15], setpoint_q} + $signed({1'b0, deadband_q});
    wire signed [16:0] tempExt = {temp_q[15], temp_q}; // signed so sub-zero readings compare right
    wire               frameEnd = zeroCross && (pos_q == `FRAME_LAST);
    wire               tempWr   = regWr && (regAddr == `REG_TEMP);
    wire               hourTick = (secCnt_q == SEC_CYCLES - 1)
                                  && (hourSecs_q == HOUR_SECS - 1);
    wire        [3:0]  target   = ctrl_q[`CTRL_PROP] ? propDuty(err, slope_q)
                                                     : `DUTY_FULL;
    wire        [28:0] limScaled = {19'h0, plimit_q} * {20'h0, `SAMPLES};
    wire               overLim  = {10'h0, sumCur_q} > limScaled;
    wire               underLim = {10'h0, sumCur_q} < limScaled;
    wire        [31:0] meanQuot = (errCnt_q == 20'h0) ? 32'h0
                                  : errSum_q / {12'h0, errCnt_q};
    wire        [15:0] meanNow  = meanQuot[15:0]; // mean of 17-bit errors, top bits unused

    // ==========================================
    // register writes
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= 3'h0;
            setpoint_q <= 16'h0000;
            deadband_q <= 16'h0000;
            plimit_q   <= 10'h000;
            temp_q     <= 16'h0000;
        end else if (regWr) begin
            case (regAddr)
                `REG_CTRL:     ctrl_q     <= regWrData[2:0];
                `REG_SETPOINT: setpoint_q <= regWrData;
                `REG_DEADBAND: deadband_q <= regWrData;
                `REG_PLIMIT:   plimit_q   <= regWrData[9:0];
                `REG_TEMP:     temp_q     <= regWrData; // new temperature reading
                default:       ctrl_q     <= ctrl_q;
            endcase
        end
    end

    // ==========================================
    // register reads, data one cycle after strobe
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            regRdData <= 16'h0000;
        else if (regRd) begin
            case (regAddr)
                `REG_CTRL:     regRdData <= {13'h0, ctrl_q};
                `REG_SETPOINT: regRdData <= setpoint_q;
                `REG_DEADBAND: regRdData <= deadband_q;
                `REG_PLIMIT:   regRdData <= {6'h0, plimit_q};
                `REG_TEMP:     regRdData <= temp_q;
                `REG_STATUS:   regRdData <= {4'h0, slope_q, 1'b0, slopeUp_q,
                                             demand_q, heaterOn, duty_q};
                `REG_AVG_CUR:  regRdData <= {6'h0, avgCur_q};
                `REG_AVG_GF:   regRdData <= {6'h0, avgGf_q};
                `REG_AVG_VOLT: regRdData <= {6'h0, avgVolt_q};
                `REG_MEAN_ERR: regRdData <= meanErr_q;
                default:       regRdData <= 16'h0000;
            endcase
        end else
            regRdData <= 16'h0000;
    end

    // ==========================================
    // frame position and heater switch
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos_q    <= 4'h0;
            heaterOn <= 1'b0;
        end else if (zeroCross) begin
            pos_q    <= frameEnd ? 4'h0 : pos_q + 4'h1;
            heaterOn <= patternBit(duty_q, pos_q);
        end
    end

    // ==========================================
    // sample accumulation over one frame
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sampCnt_q <= 9'h000;
            sumCur_q  <= 19'h0;
            sumGf_q   <= 19'h0;
            sumVolt_q <= 19'h0;
            avgCur_q  <= 10'h000;
            avgGf_q   <= 10'h000;
            avgVolt_q <= 10'h000;
        end else if (frameEnd) begin
            // frame closes: publish averages, restart sums
            avgCur_q  <= frameAvg(sumCur_q);
            avgGf_q   <= frameAvg(sumGf_q);
            avgVolt_q <= frameAvg(sumVolt_q);
            sampCnt_q <= 9'h000;
            sumCur_q  <= 19'h0;
            sumGf_q   <= 19'h0;
            sumVolt_q <= 19'h0;
        end else if (sampleValid && sampCnt_q != `SAMPLES) begin
            if (sampleChan == `CH_VOLT)
                sampCnt_q <= sampCnt_q + 9'h001; // a set ends on voltage
            case (sampleChan)
                `CH_CUR:  sumCur_q  <= sumCur_q + {9'h0, sampleData};
                `CH_GF:   sumGf_q   <= sumGf_q + {9'h0, sampleData};
                `CH_VOLT: sumVolt_q <= sumVolt_q + {9'h0, sampleData};
                default:  sumCur_q  <= sumCur_q;
            endcase
        end
    end

    // ==========================================
    // heat demand with hysteresis
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            hyst_q <= 1'b0;
        else if (tempExt <= lowTh)
            hyst_q <= 1'b1;
        else if (tempExt >= highTh)
            hyst_q <= 1'b0;
    end

    // ==========================================
    // duty stepping, soft start and power limit
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            duty_q   <= 4'h0;
            settle_q <= 2'h0;
            demand_q <= 1'b0;
        end else begin
            demand_q <= ctrl_q[`CTRL_HEAT_EN] && (ctrl_q[`CTRL_PROP] || hyst_q);
            if (!demand_q) begin
                duty_q   <= 4'h0;
                settle_q <= 2'h0;
            end else if (frameEnd) begin
                if (settle_q != `SETTLE_FRAMES - 2'h1)
                    settle_q <= settle_q + 2'h1;
                else begin
                    settle_q <= 2'h0;
                    if (duty_q > target)
                        duty_q <= duty_q - 4'h1;
                    else if (ctrl_q[`CTRL_PLIM_EN] && overLim && duty_q != 4'h0)
                        duty_q <= duty_q - 4'h1;
                    else if (duty_q < target &&
                             (!ctrl_q[`CTRL_PLIM_EN] || underLim))
                        duty_q <= duty_q + 4'h1;
                end
            end
        end
    end

    // ==========================================
    // hourly error statistics and slope retune
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            secCnt_q   <= 32'h0;
            hourSecs_q <= 16'h0000;
            errSum_q   <= 32'h0;
            errCnt_q   <= 20'h0;
            meanErr_q  <= 16'h0000;
            prevErr_q  <= 16'hFFFF;
            slope_q    <= `SLOPE_RST;
            slopeUp_q  <= 1'b1;
        end else begin
            if (secCnt_q == SEC_CYCLES - 1) begin
                secCnt_q   <= 32'h0;
                hourSecs_q <= hourTick ? 16'h0000 : hourSecs_q + 16'h0001;
            end else
                secCnt_q <= secCnt_q + 32'h1;
            if (hourTick) begin
                meanErr_q <= meanNow;
                prevErr_q <= meanNow;
                // a reading on the tick opens the new hour instead of being lost
                errSum_q  <= tempWr ? {15'h0, absErr} : 32'h0;
                errCnt_q  <= tempWr ? 20'h1 : 20'h0;
                if ((meanNow < prevErr_q) == slopeUp_q) begin
                    if (slope_q == `SLOPE_MAX) begin
                        slope_q   <= slope_q - 4'h1;
                        slopeUp_q <= 1'b0;
                    end else begin
                        slope_q   <= slope_q + 4'h1;
                        slopeUp_q <= 1'b1;
                    end
                end else begin
                    if (slope_q == `SLOPE_MIN) begin
                        slope_q   <= slope_q + 4'h1;
                        slopeUp_q <= 1'b1;
                    end else begin
                        slope_q   <= slope_q - 4'h1;
                        slopeUp_q <= 1'b0;
                    end
                end
            end else if (tempWr) begin
                errSum_q <= errSum_q + {15'h0, absErr};
                errCnt_q <= errCnt_q + 20'h1;
            end
        end
    end

endmodule // heater_cycle_modulation_ctrl

// ### heater_cycle_modulation_ctrl_asserts.sv
`timescale 1ns/1ps
// ==========
// checker on the top ports
module heater_ctrl_checker (
    // clock and reset
    input wire        clk_sys,
    input wire        rst_n,
    // mains
    input wire        zeroCross,
    // register port
    input wire [3:0]  regAddr,
    input wire [15:0] regWrData,
    input wire        regWr,
    input wire        regRd,
    input wire [15:0] regRdData,
    // heater switch
    input wire        heaterOn
);
    reg  [2:0] ctrlQ;
    wire       stRd = regRd && (regAddr == 4'h5);
    // shadow of the control word
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) ctrlQ <= 3'h0;
        else if (regWr && regAddr == 4'h0) ctrlQ <= regWrData[2:0];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_switch_at_zero: assert property ($changed(heaterOn) |-> $past(zeroCross))
        else $error("heater switched between crossings");
    a_read_idle: assert property (!$past(regRd) |-> regRdData == 16'h0)
        else $error("read data outside its cycle");
    a_read_unmapped: assert property (regRd && regAddr > 4'h9 |=> regRdData == 16'h0)
        else $error("unmapped read not zero");
    a_avg_ten_bit: assert property (regRd && regAddr inside {[4'h6:4'h8]}
        |=> regRdData[15:10] == 6'h0) else $error("average wider than ten bits");
    a_duty_range: assert property (stRd |=> regRdData[3:0] <= 4'hA)
        else $error("duty above full");
    a_slope_range: assert property (stRd |=> regRdData[11:8] inside {[4'h1:4'hA]})
        else $error("slope factor out of range");
    a_status_mirror: assert property (stRd |=> regRdData[4] == $past(heaterOn))
        else $error("status heater bit wrong");
    a_idle_no_duty: assert property (stRd && !ctrlQ[0] && !$past(ctrlQ[0], 3)
        |=> regRdData[5] == 1'b0 && regRdData[3:0] == 4'h0) else $error("duty without demand");
    cover property (stRd ##1 regRdData[3:0] == 4'hA);
    cover property (zeroCross ##1 $rose(heaterOn));
    cover property (regWr && regAddr == 4'h0 && regWrData[2]);
endmodule // heater_ctrl_checker

bind heater_cycle_modulation_ctrl heater_ctrl_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .zeroCross(zeroCross), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .heaterOn(heaterOn));

// ### heater_front_end_model.sv
`timescale 1ns/1ps
// ==========
// mains crossings and sampling front end
module heater_front_end_model #(
    parameter int         CYC  = 100,
    parameter logic [9:0] FULL = 10'h258,
    parameter logic [9:0] GF   = 10'h007,
    parameter logic [9:0] VOLT = 10'h3FF
) (
    // clock and reset
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    // heater switch
    input  wire logic  heaterOn,
    // mains and samples
    output logic       zeroCross,
    output logic       sampleValid,
    output logic [1:0] sampleChan,
    output logic [9:0] sampleData
);
    int  cnt;
    int  ph;
    wire inSet = (cnt >= 3) && (cnt <= 92);
    assign ph = (cnt - 3) % 3;
    // one crossing per cycle, then 30 sets of three samples
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            zeroCross <= 1'b0;
            sampleValid <= 1'b0;
            sampleChan <= 2'h3;
            sampleData <= 10'h155;
        end else begin
            cnt <= (cnt == CYC - 1) ? 0 : cnt + 1;
            zeroCross <= (cnt == 0);
            sampleValid <= inSet;
            sampleChan <= inSet ? 2'(ph) : ~sampleChan;
            if (!inSet) sampleData <= ~sampleData; // idle lines keep moving
            else if (ph == 0) sampleData <= heaterOn ? FULL : 10'h000;
            else sampleData <= (ph == 1) ? GF : VOLT;
        end
    end
endmodule // heater_front_end_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int HOURC = 3000;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        zcDly = 1'b0;
    logic        zeroCross, sampleValid, heaterOn;
    logic [1:0]  sampleChan;
    logic [9:0]  sampleData;
    logic [9:0]  mask = 10'h000;
    logic [3:0]  regAddr = 4'h0;
    logic [3:0]  lastDuty;
    logic [3:0]  sl [6];
    logic [15:0] regWrData = 16'h0000;
    logic [15:0] regRdData, v;
    logic [15:0] tmp [4] = '{16'h0015, 16'h0019, 16'h0015, 16'h000F};
    logic        dem [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    int          pos = 0;
    int          miscompares = 0;
    int          checked = 0;
    heater_cycle_modulation_ctrl #(.SEC_CYCLES(100), .HOUR_SECS(30)) dut_u (.clk_sys(clk_sys),
        .rst_n(rst_n), .zeroCross(zeroCross), .sampleValid(sampleValid),
        .sampleChan(sampleChan), .sampleData(sampleData), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .heaterOn(heaterOn));
    heater_front_end_model fe_u (.clk_sys(clk_sys), .rst_n(rst_n), .heaterOn(heaterOn),
        .zeroCross(zeroCross), .sampleValid(sampleValid), .sampleChan(sampleChan),
        .sampleData(sampleData));
    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;
    // heater state per frame position, one cycle after each crossing
    always @(posedge clk_sys) begin
        zcDly <= zeroCross;
        if (zcDly) begin
            mask[pos] <= heaterOn;
            pos <= (pos == 9) ? 0 : pos + 1;
        end
    end
    // ==========
    // access tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask
    function automatic logic [9:0] pat(input logic [3:0] d);
        for (int p = 0; p < 10; p++) pat[p] = ((p + 1) * d / 10) != (p * d / 10);
    endfunction
    // duty read mid-frame, then the whole frame compared with its pattern
    task automatic run_frames(input int n, input logic [3:0] step);
        logic [3:0] prev;
        logic [3:0] nxt;
        bit         chg;
        for (int i = 0; i < n; i++) begin
            do @(posedge clk_sys); while (pos != 5);
            rd(4'h5);
            nxt = prev + step; // four-bit wrap turns F into a step down
            if (i > 0) chk("duty step", (v[3:0] === prev) ? prev : nxt, v[3:0]);
            if (i > 0 && chg) chk("duty settle", prev, v[3:0]);
            chg = (i > 0) && (v[3:0] !== prev);
            prev = v[3:0];
            do @(posedge clk_sys); while (pos != 0);
            chk("frame pattern", pat(prev), mask);
        end
        lastDuty = prev;
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========
    // main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(4'h5);
        chk("status reset", 16'h0540, v);
        wr(4'h5, 16'hFFFF);
        rd(4'h5);
        chk("status read only", 16'h0540, v);
        rd(4'hF);
        chk("unmapped", 16'h0000, v);
        wr(4'h1, 16'h0014);
        wr(4'h2, 16'h0005);
        wr(4'h4, 16'h000A);
        rd(4'h1);
        chk("setpoint", 16'h0014, v);
        wr(4'h0, 16'h0001);
        run_frames(24, 4'h1);
        chk("soft start end", 16'h000A, lastDuty);
        wr(4'h3, 16'h012C);
        wr(4'h0, 16'h0005);
        run_frames(14, 4'hF);
        chk("limited duty", 16'h0005, lastDuty);
        rd(4'h6);
        chk("avg current", 16'h012C, v);
        rd(4'h8);
        chk("avg voltage", 16'h03FF, v);
        rd(4'h7);
        chk("avg fault", 16'h0007, v);
        wr(4'h3, 16'h01A4);
        run_frames(8, 4'h1);
        chk("raised duty", 16'h0007, lastDuty);
        wr(4'h0, 16'h0003);
        wr(4'h4, 16'h0008);
        run_frames(9, 4'h1);
        chk("prop full", 16'h000A, lastDuty);
        wr(4'h4, 16'h0015);
        run_frames(4, 4'hF);
        chk("prop falling", 16'h0001, {15'h0, lastDuty < 4'hA});
        wr(4'h0, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            wr(4'h4, tmp[i]);
            repeat (3) @(posedge clk_sys); // hysteresis, demand and duty each take an edge
            rd(4'h5);
            chk("demand", dem[i], v[5]);
            if (!dem[i] || i == 3) chk("idle duty", 16'h0000, v[3:0]);
        end
        wr(4'h0, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            repeat (HOURC - 8) @(posedge clk_sys);
            wr(4'h4, 16'h0010);
            wr(4'h4, 16'h0018);
            rd(4'h9);
            if (k > 1) chk("hour mean", 16'h0004, v);
            rd(4'h5);
            sl[k] = v[11:8];
            if (k > 3) chk("slope reverse", sl[k - 2], sl[k]);
            if (k > 3) chk("slope step", 16'h0001, {15'h0, (sl[k] - sl[k - 1] == 4'h1)
                || (sl[k - 1] - sl[k] == 4'h1)});
        end
        report_and_stop;
    end
    // watchdog against a hang
    initial begin
        repeat (95000) @(posedge clk_sys);
        miscompares++;
        report_and_stop;
    end
endmodule // testbench
